//--- include/mcs_regs.svh
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH
// register addresses (serial command byte, low six bits)
`define ADDR_CTRL 6'h01
`define ADDR_TALLY 6'h08
`define ADDR_CHAN0 6'h09
`define ADDR_CHAN15 6'h18
`define ADDR_CFG0 6'h19
`define ADDR_CFG7 6'h20
`define ADDR_OFF0 6'h29
`define ADDR_OFF7 6'h30
`define ADDR_GAIN0 6'h31
`define ADDR_GAIN7 6'h38
// command byte bits
`define CMD_WEN_BIT 7
`define CMD_RD_BIT 6
// reset values
`define CTRL_RESET 16'h0000
`define CFG_RESET 16'h0860
`define OFF_RESET 24'h800000
`define CHAN_RESET 16'h0001
`define TALLY_RESET 8'h00
// channel register fields
`define CH_EN 15
`define CH_SETUP_HI 14
`define CH_SETUP_LO 12
`define CH_POS_HI 9
`define CH_POS_LO 5
`define CH_NEG_HI 4
`define CH_NEG_LO 0
// setup configuration fields
`define CFG_BUFP 6
`define CFG_BUFM 5
`define CFG_PGA_HI 2
`define CFG_PGA_LO 0
`define PGA_UNITY 3'h0
// control register mode field and encodings
`define CTRL_MODE_HI 5
`define CTRL_MODE_LO 2
`define MODE_CONT 4'h0
`define MODE_IDLE 4'h4
`define MODE_ZS_INT 4'h5
`define MODE_FS_INT 4'h6
`define MODE_ZS_SYS 4'h7
`define MODE_FS_SYS 4'h8
// transfer lengths in bits
`define LEN8 5'h08
`define LEN16 5'h10
`define LEN24 5'h18
`define LAST_CMD_BIT 5'h07
`endif

//--- include/mcs_pkg.sv
package mcs_pkg;
	typedef enum logic [0:0] {
		PH_CMD = 1'b0,
		PH_DATA = 1'b1
	} spi_phase_t;
	typedef logic [15:0] word16_t;
	typedef logic [23:0] word24_t;
endpackage

//--- design/multiplexed_channel_sequencer.sv
// Notes on behaviour
// - channel holds five-bit positive and negative picks
// - any of sixteen pins on either side
// - channel msb enables it for conversion
// - ascending order through enabled channels, wrap around
// - eight setups, channel setup field selects one
// - gain and offset coefficients kept per setup
// - calibration writes coefficient of selected channel's setup
// - separate enable bits for both input buffers
// - gain above one forces both buffers on
// - unity gain powers down and bypasses amplifier
// - offset registers reset to mid-scale
// - tally counts master clock pulses, one step per TALLY_DIV pulses
`timescale 1ns/1ps
`include "mcs_regs.svh"
module multiplexed_channel_sequencer import mcs_pkg::*; #(
	parameter logic [23:0] GAIN_INIT = 24'h500000,
	parameter int TALLY_DIV = 1
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic conv_done,
	input wire logic cal_done,
	input wire logic [23:0] cal_coef,
	output logic sdo,
	output logic sdo_oe,
	output logic converting,
	output logic [3:0] active_chan,
	output logic [4:0] positive_input_pick,
	output logic [4:0] negative_input_pick,
	output logic [2:0] active_setup,
	output logic positive_input_buffer_on,
	output logic negative_input_buffer_on,
	output logic pga_powered,
	output logic [2:0] pga_gain,
	output logic [23:0] offset_coef,
	output logic [23:0] gain_coef
);
	// pin synchronisers; stage 0 feeds only stage 1
	logic [2:0] sclk_s;
	logic [2:0] cs_s;
	logic [1:0] sdi_s;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sclk_s <= 3'h7;
			cs_s <= 3'h7;
			sdi_s <= 2'h0;
		end else begin
			sclk_s <= {sclk_s[1:0], sclk};
			cs_s <= {cs_s[1:0], cs_n};
			sdi_s <= {sdi_s[0], sdi};
		end
	end
	wire sck_rise = sclk_s[1] & ~sclk_s[2];
	wire sck_fall = ~sclk_s[1] & sclk_s[2];
	wire sel = ~cs_s[1];
	wire din = sdi_s[1];

	// register state
	word16_t ctrl_r, ctrl_nxt;
	word16_t chan_r [16];
	word16_t chan_nxt [16];
	word16_t cfg_r [8];
	word16_t cfg_nxt [8];
	word24_t off_r [8];
	word24_t off_nxt [8];
	word24_t gain_r [8];
	word24_t gain_nxt [8];
	logic [7:0] tally_r, tally_nxt;
	logic [15:0] div_r, div_nxt;
	logic [3:0] cur_r, cur_nxt;

	// serial port state
	spi_phase_t phase_r, phase_nxt;
	logic [4:0] bitcnt_r, bitcnt_nxt;
	logic [7:0] cmd_r, cmd_nxt;
	word24_t shin_r, shin_nxt, shout_r, shout_nxt;
	logic sdo_nxt, sdo_oe_nxt;
	logic wr_stb;
	word24_t wr_data;
	word24_t rd_word;
	logic [4:0] rd_len, len;
	logic [5:0] rd_addr;

	wire [3:0] mode = ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO];
	wire [2:0] cur_setup = chan_r[cur_r][`CH_SETUP_HI:`CH_SETUP_LO];

	// length of a register by address; unmapped reads as one zero byte
	function automatic logic [4:0] reg_len(input logic [5:0] a);
		if (a == `ADDR_CTRL || (a >= `ADDR_CHAN0 && a <= `ADDR_CFG7))
			reg_len = `LEN16;
		else if (a >= `ADDR_OFF0 && a <= `ADDR_GAIN7)
			reg_len = `LEN24;
		else
			reg_len = `LEN8;
	endfunction

	// readback, left aligned so the msb shifts out first
	always_comb begin
		rd_addr = {cmd_r[4:0], din};
		rd_len = reg_len(rd_addr);
		rd_word = '0;
		if (rd_addr == `ADDR_CTRL)
			rd_word = {ctrl_r, 8'h00};
		else if (rd_addr == `ADDR_TALLY)
			rd_word = {tally_r, 16'h0000};
		else if (rd_addr >= `ADDR_CHAN0 && rd_addr <= `ADDR_CHAN15)
			rd_word = {chan_r[4'(rd_addr - `ADDR_CHAN0)], 8'h00};
		else if (rd_addr >= `ADDR_CFG0 && rd_addr <= `ADDR_CFG7)
			rd_word = {cfg_r[3'(rd_addr - `ADDR_CFG0)], 8'h00};
		else if (rd_addr >= `ADDR_OFF0 && rd_addr <= `ADDR_OFF7)
			rd_word = off_r[3'(rd_addr - `ADDR_OFF0)];
		else if (rd_addr >= `ADDR_GAIN0 && rd_addr <= `ADDR_GAIN7)
			rd_word = gain_r[3'(rd_addr - `ADDR_GAIN0)];
	end

	// serial framing: command byte then a register-length data field,
	// sampled on sclk rise, shifted out on sclk fall
	always_comb begin
		phase_nxt = phase_r;
		bitcnt_nxt = bitcnt_r;
		cmd_nxt = cmd_r;
		shin_nxt = shin_r;
		shout_nxt = shout_r;
		sdo_nxt = sdo;
		sdo_oe_nxt = sel;
		wr_stb = 1'b0;
		len = reg_len(cmd_r[5:0]);
		wr_data = {shin_r[22:0], din};
		if (!sel) begin
			phase_nxt = PH_CMD;
			bitcnt_nxt = '0;
		end else if (sck_rise) begin
			if (phase_r == PH_CMD) begin
				cmd_nxt = {cmd_r[6:0], din};
				bitcnt_nxt = bitcnt_r + 5'h01;
				if (bitcnt_r == `LAST_CMD_BIT) begin
					phase_nxt = PH_DATA;
					bitcnt_nxt = '0;
					shout_nxt = rd_word;
				end
			end else begin
				shin_nxt = wr_data;
				bitcnt_nxt = bitcnt_r + 5'h01;
				if (bitcnt_r == len - 5'h01) begin
					// a write needs the enable bit low and the read bit low
					wr_stb = ~cmd_r[`CMD_WEN_BIT] & ~cmd_r[`CMD_RD_BIT];
					phase_nxt = PH_CMD;
					bitcnt_nxt = '0;
				end
			end
		end else if (sck_fall && phase_r == PH_DATA) begin
			sdo_nxt = shout_r[23];
			shout_nxt = {shout_r[22:0], 1'b0};
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			phase_r <= PH_CMD;
			bitcnt_r <= '0;
			cmd_r <= 8'h00;
			shin_r <= '0;
			shout_r <= '0;
			sdo <= 1'b0;
			sdo_oe <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			bitcnt_r <= bitcnt_nxt;
			cmd_r <= cmd_nxt;
			shin_r <= shin_nxt;
			shout_r <= shout_nxt;
			sdo <= sdo_nxt;
			sdo_oe <= sdo_oe_nxt;
		end
	end

	// register file: software writes, calibration results, clock tally;
	// calibration is applied after a software write so the result wins
	always_comb begin
		logic [5:0] a;
		a = cmd_r[5:0];
		ctrl_nxt = ctrl_r;
		chan_nxt = chan_r;
		cfg_nxt = cfg_r;
		off_nxt = off_r;
		gain_nxt = gain_r;
		tally_nxt = tally_r;
		div_nxt = div_r + 16'h0001;
		if (div_r == 16'(TALLY_DIV - 1)) begin
			div_nxt = '0;
			tally_nxt = tally_r + 8'h01;
		end
		if (wr_stb) begin
			if (a == `ADDR_CTRL)
				ctrl_nxt = wr_data[15:0];
			else if (a >= `ADDR_CHAN0 && a <= `ADDR_CHAN15)
				chan_nxt[4'(a - `ADDR_CHAN0)] = wr_data[15:0];
			else if (a >= `ADDR_CFG0 && a <= `ADDR_CFG7)
				cfg_nxt[3'(a - `ADDR_CFG0)] = wr_data[15:0];
			else if (a >= `ADDR_OFF0 && a <= `ADDR_OFF7)
				off_nxt[3'(a - `ADDR_OFF0)] = wr_data;
			else if (a >= `ADDR_GAIN0 && a <= `ADDR_GAIN7)
				gain_nxt[3'(a - `ADDR_GAIN0)] = wr_data;
		end
		if (cal_done) begin
			if (mode == `MODE_ZS_INT || mode == `MODE_ZS_SYS)
				off_nxt[cur_setup] = cal_coef;
			if (mode == `MODE_FS_INT || mode == `MODE_FS_SYS)
				gain_nxt[cur_setup] = cal_coef;
			if (mode >= `MODE_ZS_INT && mode <= `MODE_FS_SYS)
				ctrl_nxt[`CTRL_MODE_HI:`CTRL_MODE_LO] = `MODE_IDLE;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= `CTRL_RESET;
			tally_r <= `TALLY_RESET;
			div_r <= '0;
			for (int i = 0; i < 16; i++)
				chan_r[i] <= `CHAN_RESET;
			for (int i = 0; i < 8; i++) begin
				cfg_r[i] <= `CFG_RESET;
				off_r[i] <= `OFF_RESET;
				gain_r[i] <= GAIN_INIT;
			end
		end else begin
			ctrl_r <= ctrl_nxt;
			chan_r <= chan_nxt;
			cfg_r <= cfg_nxt;
			off_r <= off_nxt;
			gain_r <= gain_nxt;
			tally_r <= tally_nxt;
			div_r <= div_nxt;
		end
	end

	// sequencer: next enabled channel above the current one, wrapping;
	// with one enabled channel the search lands back on itself
	always_comb begin
		logic [3:0] idx;
		logic found;
		idx = '0;
		found = 1'b0;
		cur_nxt = cur_r;
		if (conv_done && mode == `MODE_CONT) begin
			for (int i = 1; i <= 16; i++) begin
				idx = cur_r + i[3:0];
				if (!found && chan_r[idx][`CH_EN]) begin
					cur_nxt = idx;
					found = 1'b1;
				end
			end
		end
	end

	// steering outputs follow the current channel and its setup
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cur_r <= '0;
			converting <= 1'b0;
			active_chan <= '0;
			positive_input_pick <= '0;
			negative_input_pick <= '0;
			active_setup <= '0;
			positive_input_buffer_on <= 1'b0;
			negative_input_buffer_on <= 1'b0;
			pga_powered <= 1'b0;
			pga_gain <= '0;
			offset_coef <= `OFF_RESET;
			gain_coef <= GAIN_INIT;
		end else begin
			cur_r <= cur_nxt;
			converting <= (mode == `MODE_CONT) && chan_r[cur_r][`CH_EN];
			active_chan <= cur_r;
			// pin codes 0 to 15 reach every analog input on either side
			positive_input_pick <= chan_r[cur_r][`CH_POS_HI:`CH_POS_LO];
			negative_input_pick <= chan_r[cur_r][`CH_NEG_HI:`CH_NEG_LO];
			active_setup <= cur_setup;
			positive_input_buffer_on <= cfg_r[cur_setup][`CFG_BUFP] |
				(cfg_r[cur_setup][`CFG_PGA_HI:`CFG_PGA_LO] != `PGA_UNITY);
			negative_input_buffer_on <= cfg_r[cur_setup][`CFG_BUFM] |
				(cfg_r[cur_setup][`CFG_PGA_HI:`CFG_PGA_LO] != `PGA_UNITY);
			pga_powered <=
				cfg_r[cur_setup][`CFG_PGA_HI:`CFG_PGA_LO] != `PGA_UNITY;
			pga_gain <= cfg_r[cur_setup][`CFG_PGA_HI:`CFG_PGA_LO];
			offset_coef <= off_r[cur_setup];
			gain_coef <= gain_r[cur_setup];
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	a_buf_forced: assert property (pga_gain != `PGA_UNITY |->
		positive_input_buffer_on && negative_input_buffer_on)
		else $error("buffers not forced on above unity gain");
	a_pga_bypass: assert property (
		pga_powered == (pga_gain != `PGA_UNITY))
		else $error("amplifier power does not follow gain");
	a_off_hold: assert property ($changed(off_r[0]) |->
		$past(wr_stb) || $past(cal_done))
		else $error("offset changed without write or calibration");
	a_seq_enabled: assert property ($changed(cur_r) |->
		chan_r[cur_r][`CH_EN] && $past(conv_done))
		else $error("sequencer moved to a disabled channel");
	a_tally_step: assert property (div_r == 16'(TALLY_DIV - 1) |=>
		tally_r == $past(tally_r) + 8'h01)
		else $error("tally did not advance");
	a_cal_gain: assert property (cal_done && mode == `MODE_FS_INT |=>
		gain_r[$past(cur_setup)] == $past(cal_coef))
		else $error("calibration gain not stored");
	a_setup_sel: assert property (1'b1 |=>
		active_setup == $past(cur_setup))
		else $error("active setup does not follow channel");
	a_route: assert property (1'b1 |=>
		positive_input_pick == $past(chan_r[cur_r][`CH_POS_HI:`CH_POS_LO]))
		else $error("positive pick does not follow channel");
	a_coef_pick: assert property (1'b1 |=>
		gain_coef == $past(gain_r[cur_setup]))
		else $error("gain coefficient not from active setup");
endmodule

//--- tb/multiplexed_channel_sequencer_bench.sv
`timescale 1ns/1ps
`include "mcs_regs.svh"
module multiplexed_channel_sequencer_bench import mcs_pkg::*;;
	localparam logic [23:0] GAIN_START = 24'h5a0000;
	logic mclk, arst_n, sclk, cs_n, sdi, conv_done, cal_done;
	logic [23:0] cal_coef, rd;
	logic sdo, sdo_oe, converting, positive_input_buffer_on;
	logic negative_input_buffer_on, pga_powered;
	logic [3:0] active_chan;
	logic [4:0] positive_input_pick, negative_input_pick;
	logic [2:0] active_setup, pga_gain;
	logic [23:0] offset_coef, gain_coef;
	int error_cnt, check_count;

	multiplexed_channel_sequencer #(.GAIN_INIT(GAIN_START)) uut (
		.mclk(mclk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
		.conv_done(conv_done), .cal_done(cal_done), .cal_coef(cal_coef),
		.sdo(sdo), .sdo_oe(sdo_oe), .converting(converting),
		.active_chan(active_chan),
		.positive_input_pick(positive_input_pick),
		.negative_input_pick(negative_input_pick),
		.active_setup(active_setup),
		.positive_input_buffer_on(positive_input_buffer_on),
		.negative_input_buffer_on(negative_input_buffer_on),
		.pga_powered(pga_powered), .pga_gain(pga_gain),
		.offset_coef(offset_coef), .gain_coef(gain_coef)
	);

	// 100 ns master clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// inputs always move 5 ns after the rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#5;
	endtask

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one serial frame; six mclk per sclk phase keeps the synchroniser happy
	task automatic xfer(input logic [7:0] cmd, input logic [23:0] d,
			input int n);
		logic [31:0] s;
		int i;
		s = {cmd, d << (24 - n)};
		cs_n = 1'b0;
		tick(6);
		chk({23'h0, sdo_oe}, 24'h1);
		rd = '0;
		for (i = 0; i < 8 + n; i++) begin
			sclk = 1'b0;
			sdi = s[31-i];
			tick(6);
			sclk = 1'b1;
			tick(6);
			if (i >= 8) rd = {rd[22:0], sdo};
		end
		cs_n = 1'b1;
		tick(6);
	endtask

	task automatic wr(input logic [5:0] a, input logic [23:0] d, input int n);
		xfer({2'b00, a}, d, n);
	endtask

	task automatic rdchk(input logic [5:0] a, input logic [23:0] e,
			input int n);
		xfer({2'b01, a}, 24'h000000, n);
		chk(rd, e);
	endtask

	// one conversion finished; steering follows two cycles later
	task automatic step;
		conv_done = 1'b1;
		tick(1);
		conv_done = 1'b0;
		tick(4);
	endtask

	task automatic route(input logic [3:0] c, input logic [4:0] p,
			input logic [4:0] m, input logic [2:0] s, input logic [5:0] f);
		chk({7'h00, c, p, m, s}, {7'h00, active_chan, positive_input_pick,
			negative_input_pick, active_setup});
		chk({18'h0, f}, {18'h0, positive_input_buffer_on,
			negative_input_buffer_on, pga_powered, pga_gain});
	endtask

	task automatic calib(input logic [23:0] c);
		cal_coef = c;
		cal_done = 1'b1;
		tick(1);
		cal_done = 1'b0;
		tick(3);
	endtask

	task automatic t_reset;
		route(4'h0, 5'h00, 5'h01, 3'h0, 6'h30);
		chk(offset_coef, 24'h800000);
		chk(gain_coef, GAIN_START);
		chk({23'h0, converting}, 24'h0);
		chk({23'h0, sdo_oe}, 24'h0);
		rdchk(6'h20, 24'h000860, 16);
		rdchk(6'h01, 24'h000000, 16);
		rdchk(6'h3f, 24'h000000, 8);
	endtask

	// two identical tally reads lie one 204-cycle frame apart
	task automatic t_tally;
		logic [7:0] first;
		xfer({2'b01, 6'h08}, 24'h000000, 8);
		first = rd[7:0];
		xfer({2'b01, 6'h08}, 24'h000000, 8);
		chk({16'h0, rd[7:0] - first}, 24'h0000cc);
	endtask

	// three enabled channels, each on its own setup
	task automatic t_seq;
		wr(6'h19 + 6'h01, 24'h000003, 16);
		wr(6'h19 + 6'h02, 24'h000040, 16);
		wr(6'h09, 24'h008020, 16);
		wr(6'h09 + 6'h02, 24'h009062, 16);
		wr(6'h09 + 6'h05, 24'h00a1ee, 16);
		rdchk(6'h09 + 6'h05, 24'h00a1ee, 16);
		wr(6'h08, 24'h0000ff, 8);
		chk({23'h0, converting}, 24'h1);
		route(4'h0, 5'h01, 5'h00, 3'h0, 6'h30);
		step;
		route(4'h2, 5'h03, 5'h02, 3'h1, 6'h3b);
		step;
		route(4'h5, 5'h0f, 5'h0e, 3'h2, 6'h20);
		step;
		route(4'h0, 5'h01, 5'h00, 3'h0, 6'h30);
		step;
		chk({20'h0, active_chan}, 24'h2);
		chk({23'h0, pga_powered}, 24'h1);
	endtask

	// calibrations on channel 2, whose setup is 1
	task automatic t_cal;
		wr(6'h01, 24'h000018, 16);
		step;
		chk({20'h0, active_chan}, 24'h2);
		calib(24'h123456);
		chk(gain_coef, 24'h123456);
		rdchk(6'h31 + 6'h01, 24'h123456, 24);
		rdchk(6'h31, GAIN_START, 24);
		rdchk(6'h01, 24'h000010, 16);
		wr(6'h01, 24'h000014, 16);
		calib(24'h00abcd);
		chk(offset_coef, 24'h00abcd);
		rdchk(6'h29 + 6'h01, 24'h00abcd, 24);
		rdchk(6'h29, 24'h800000, 24);
	endtask

	// only channel 0 left enabled
	task automatic t_single;
		wr(6'h01, 24'h000000, 16);
		wr(6'h09 + 6'h02, 24'h000000, 16);
		wr(6'h09 + 6'h05, 24'h000000, 16);
		step;
		route(4'h0, 5'h01, 5'h00, 3'h0, 6'h30);
		step;
		chk({20'h0, active_chan}, 24'h0);
		chk(offset_coef, 24'h800000);
	endtask

	task automatic close_out;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// whole run is near 6.6k cycles; give it ample headroom
	initial begin
		#5000000;
		error_cnt++;
		close_out();
	end

	initial begin
		arst_n = 1'b0;
		sclk = 1'b1;
		cs_n = 1'b1;
		sdi = 1'b0;
		conv_done = 1'b0;
		cal_done = 1'b0;
		cal_coef = 24'h000000;
		error_cnt = 0;
		check_count = 0;
		tick(2);
		arst_n = 1'b1;
		tick(3);
		t_reset();
		t_tally();
		t_seq();
		t_cal();
		t_single();
		close_out();
	end
endmodule
